// *** rtl/engine_end.sv ***
// Purpose: print engine end of the command/status and video link
// Assumes: one clock, synchronous active-high reset
// Notes:   one uart core per end; no buffering of video
`timescale 1ns/1ns
module engine_end #(
    parameter int BIT_CYCLES = engine_link_pkg::BIT_CYCLES  // clocks per serial bit
) (
    input  wire logic       clk,
    input  wire logic       reset,
    engine_link_if.engine   link,
    input  wire logic       engineOk,     // mechanics warmed up and able
    input  wire logic [3:0] keySwitches,  // control panel key levels
    input  wire logic       pageStart,    // one-cycle pulse: page top reached
    input  wire logic [7:0] statusData,   // reply byte for the current command
    input  wire logic       statusSend,   // pulse: send reply now
    output logic            statusBusy,
    output logic [7:0]      cmdData,
    output logic            cmdValid,     // pulse: good command received
    output logic            cmdError,     // pulse: character discarded
    output logic            linkUp,       // initialize command seen
    output logic            awaitReply,   // command taken, reply owed
    output logic            laserOn,
    output logic            lineStart     // hsync registered for scan timing
);
    logic       txLine;
    logic       txBusy;
    logic [7:0] rxByte;
    logic       rxValid;
    logic       rxErr;
    logic [3:0] keyPrev_reg;
    logic       gotInit_reg;
    logic       replyOwed_reg;

    uart_core #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_uart (
        .clk     (clk),
        .reset   (reset),
        .rxLine  (link.commandLine),
        .txData  (statusData),
        .txStart (statusSend & replyOwed_reg),
        .txLine  (txLine),
        .txBusy  (txBusy),
        .rxData  (rxByte),
        .rxValid (rxValid),
        .rxError (rxErr)
    );

    // status line only carries replies owed to a command
    always_ff @(posedge clk) begin
        if (reset) begin
            replyOwed_reg <= 1'b0;
        end else if (rxValid) begin
            replyOwed_reg <= 1'b1;
        end else if (statusSend) begin
            replyOwed_reg <= 1'b0;
        end
    end

    // link counts as up once the initialize command arrives
    always_ff @(posedge clk) begin
        if (reset) begin
            gotInit_reg <= 1'b0;
        end else if (rxValid && rxByte == engine_link_pkg::CMD_INIT) begin
            gotInit_reg <= 1'b1;
        end
    end

    // discrete outputs, all registered
    always_ff @(posedge clk) begin
        if (reset) begin
            link.statusLine   <= engine_link_pkg::LINE_IDLE;
            link.engine_ready <= 1'b0;
            link.keyChange    <= 1'b0;
            link.vsync        <= 1'b0;
            keyPrev_reg       <= 4'h0;
        end else begin
            link.statusLine   <= txLine;
            link.engine_ready <= engineOk;
            keyPrev_reg       <= keySwitches;
            // sticky until the controller reads status by a command
            if (keySwitches != keyPrev_reg) begin
                link.keyChange <= 1'b1;
            end else if (rxValid) begin
                link.keyChange <= 1'b0;
            end
            link.vsync        <= pageStart & link.print_request;
        end
    end

    // user side outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            cmdData    <= 8'h00;
            cmdValid   <= 1'b0;
            cmdError   <= 1'b0;
            linkUp     <= 1'b0;
            awaitReply <= 1'b0;
            statusBusy <= 1'b0;
            laserOn    <= 1'b0;
            lineStart  <= 1'b0;
        end else begin
            cmdData    <= rxByte;
            cmdValid   <= rxValid;
            cmdError   <= rxErr;
            linkUp     <= gotInit_reg;
            awaitReply <= replyOwed_reg;
            statusBusy <= txBusy;
            laserOn    <= link.video;
            lineStart  <= link.hsync;
        end
    end
endmodule : engine_end

// shared serial engine: one transmitter, one receiver
module uart_core #(
    parameter int BIT_CYCLES = engine_link_pkg::BIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       rxLine,
    input  wire logic [7:0] txData,
    input  wire logic       txStart,
    output logic            txLine,
    output logic            txBusy,
    output logic [7:0]      rxData,
    output logic            rxValid,
    output logic            rxError
);
    localparam logic [13:0] BIT_END  = 14'(BIT_CYCLES - 1);
    localparam logic [13:0] HALF_END = 14'(BIT_CYCLES / 2 - 1);
    logic [10:0] txShift_reg;
    logic [3:0]  txCount_reg;
    logic [13:0] txTimer_reg;
    logic [13:0] rxTimer_reg;
    logic [3:0]  rxCount_reg;
    logic [9:0]  rxShift_reg;
    logic        rxActive_reg;

    // transmitter: frame held as shift word, lsb leaves first
    always_ff @(posedge clk) begin
        if (reset) begin
            txShift_reg <= 11'h7FF;
            txCount_reg <= 4'h0;
            txTimer_reg <= 14'h0000;
            txBusy      <= 1'b0;
            txLine      <= 1'b1;
        end else if (!txBusy) begin
            txLine <= engine_link_pkg::LINE_IDLE;
            if (txStart) begin
                txShift_reg <= {1'b1, engine_link_pkg::oddParity(txData), txData, 1'b0};
                txCount_reg <= 4'hB;
                txTimer_reg <= 14'h0000;
                txBusy      <= 1'b1;
            end
        end else begin
            txLine <= txShift_reg[0];
            if (txTimer_reg == BIT_END) begin
                txTimer_reg <= 14'h0000;
                txShift_reg <= {1'b1, txShift_reg[10:1]};
                txCount_reg <= txCount_reg - 4'h1;
                if (txCount_reg == 4'h1) begin
                    txBusy <= 1'b0;
                end
            end else begin
                txTimer_reg <= txTimer_reg + 14'h0001;
            end
        end
    end

    // receiver: find start edge, sample mid bit
    always_ff @(posedge clk) begin
        if (reset) begin
            rxActive_reg <= 1'b0;
            rxTimer_reg  <= 14'h0000;
            rxCount_reg  <= 4'h0;
            rxShift_reg  <= 10'h000;
            rxData       <= 8'h00;
            rxValid      <= 1'b0;
            rxError      <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            rxError <= 1'b0;
            if (!rxActive_reg) begin
                if (rxLine == engine_link_pkg::START_LEVEL) begin
                    rxActive_reg <= 1'b1;
                    rxTimer_reg  <= 14'h0000;
                    rxCount_reg  <= 4'h0;
                end
            end else if ((rxCount_reg == 4'h0 && rxTimer_reg == HALF_END) ||
                         (rxCount_reg != 4'h0 && rxTimer_reg == BIT_END)) begin
                rxTimer_reg <= 14'h0000;
                rxCount_reg <= rxCount_reg + 4'h1;
                if (rxCount_reg == 4'h0) begin
                    // glitch rather than start bit: back to idle
                    if (rxLine != engine_link_pkg::START_LEVEL) begin
                        rxActive_reg <= 1'b0;
                    end
                end else if (rxCount_reg == 4'hA) begin
                    rxActive_reg <= 1'b0;
                    // bad parity or missing stop discards the byte
                    if (rxLine && (^rxShift_reg[9:1]) == 1'b1) begin
                        rxData  <= rxShift_reg[8:1];
                        rxValid <= 1'b1;
                    end else begin
                        rxError <= 1'b1;
                    end
                end else begin
                    rxShift_reg <= {rxLine, rxShift_reg[9:1]};
                end
            end else begin
                rxTimer_reg <= rxTimer_reg + 14'h0001;
            end
        end
    end
endmodule : uart_core

// *** include/engine_link_pkg.sv ***
// Purpose: shared constants for the engine command/status link
// Assumes: 125 MHz system clock
// Notes:   serial character is start, 8 data lsb first, odd parity, stop
package engine_link_pkg;
    localparam int          CLK_HZ        = 125_000_000;
    localparam int          BIT_RATE      = 9600;
    // cycles per bit, rounded down so the character never runs long
    localparam int          BIT_CYCLES    = CLK_HZ / BIT_RATE;
    localparam int          HALF_CYCLES   = BIT_CYCLES / 2;
    localparam int          DATA_BITS     = 8;
    localparam int          CNT_W         = 14;
    localparam logic        LINE_IDLE     = 1'b1;
    localparam logic        START_LEVEL   = 1'b0;
    localparam logic [7:0]  CMD_INIT      = 8'h00;
    // odd parity: data plus parity bit holds an odd count of ones
    function automatic logic oddParity(input logic [7:0] d);
        return ~(^d);
    endfunction : oddParity
endpackage : engine_link_pkg

// *** include/engine_link_if.sv ***
// Purpose: wires between the video controller and the print engine
// Assumes: all lines synchronous to clk, true-high levels inside the chip
// Notes:   pad inversion of the -N pins is outside this interface
`timescale 1ns/1ns
interface engine_link_if;
    logic commandLine;   // controller to engine serial, idles high
    logic statusLine;    // engine to controller serial, idles high
    logic engine_ready;
    logic print_request;
    logic keyChange;
    logic vsync;
    logic hsync;
    logic video;
    modport engine (input commandLine, print_request, hsync, video,
                    output statusLine, engine_ready, keyChange, vsync);
    modport controller (output commandLine, print_request, hsync, video,
                        input statusLine, engine_ready, keyChange, vsync);
endinterface : engine_link_if

// *** rtl/controller_end.sv ***
// Purpose: video controller end of the engine command/status link
// Assumes: uart_core from the engine end file is compiled first
// Notes:   commands refused while a reply is outstanding
`timescale 1ns/1ns
module controller_end #(
    parameter int BIT_CYCLES = engine_link_pkg::BIT_CYCLES  // clocks per serial bit
) (
    input  wire logic         clk,
    input  wire logic         reset,
    engine_link_if.controller link,
    input  wire logic [7:0]   cmdData,
    input  wire logic         cmdSend,     // pulse; ignored unless cmdReady, or in the first cycle after a reply clears the wait
    output logic              cmdReady,
    output logic [7:0]        statusData,
    output logic              statusValid, // pulse
    output logic              statusError, // pulse: reply discarded
    output logic              linkUp,
    input  wire logic         pageWanted,
    input  wire logic         lineSync,
    input  wire logic         dot,
    output logic              engineReady,
    output logic              keyChanged,
    output logic              pageTop
);
    logic       txLine;
    logic       txBusy;
    logic       txGo;
    logic [7:0] txByte;
    logic [7:0] rxByte;
    logic       rxValid;
    logic       rxErr;
    logic       initDone_reg;
    logic       initSent_reg;
    logic       waiting_reg;

    // initialize goes out first after reset, user commands only once it is answered
    assign txGo   = !waiting_reg && !txBusy && (!initSent_reg || (cmdSend && initDone_reg));
    assign txByte = initSent_reg ? cmdData : engine_link_pkg::CMD_INIT;

    uart_core #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_uart (
        .clk     (clk),
        .reset   (reset),
        .rxLine  (link.statusLine),
        .txData  (txByte),
        .txStart (txGo),
        .txLine  (txLine),
        .txBusy  (txBusy),
        .rxData  (rxByte),
        .rxValid (rxValid),
        .rxError (rxErr)
    );

    // one command outstanding until its reply, good or bad
    always_ff @(posedge clk) begin
        if (reset) begin
            waiting_reg  <= 1'b0;
            initSent_reg <= 1'b0;
            initDone_reg <= 1'b0;
        end else begin
            if (txGo) begin
                waiting_reg  <= 1'b1;
                initSent_reg <= 1'b1;
            end else if (rxValid || rxErr) begin
                waiting_reg  <= 1'b0;
                initDone_reg <= initDone_reg | rxValid;
            end
        end
    end

    // pins and user outputs, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            link.commandLine   <= engine_link_pkg::LINE_IDLE;
            link.print_request <= 1'b0;
            link.hsync         <= 1'b0;
            link.video         <= 1'b0;
            cmdReady           <= 1'b0;
            statusData         <= 8'h00;
            statusValid        <= 1'b0;
            statusError        <= 1'b0;
            linkUp             <= 1'b0;
            engineReady        <= 1'b0;
            keyChanged         <= 1'b0;
            pageTop            <= 1'b0;
        end else begin
            link.commandLine   <= txLine;
            link.print_request <= pageWanted & initDone_reg;
            link.hsync         <= lineSync;
            link.video         <= dot;
            cmdReady           <= initDone_reg && !waiting_reg && !txBusy && !txGo;
            statusData         <= rxByte;
            statusValid        <= rxValid;
            statusError        <= rxErr;
            linkUp             <= initDone_reg;
            engineReady        <= link.engine_ready;
            keyChanged         <= link.keyChange;
            pageTop            <= link.vsync;
        end
    end
endmodule : controller_end

// *** dv/engine_link_sva.sv ***
// Purpose: wire-level checks on the engine command/status link
// Assumes: one clock, synchronous active-high reset
// Notes:   frame starts found as a fall at least ten and a half bits after the previous start
`timescale 1ns/1ns
module engine_link_sva #(
    parameter int BIT_CYCLES = engine_link_pkg::BIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic commandLine,
    input wire logic statusLine,
    input wire logic print_request,
    input wire logic vsync
);
    localparam int BIT  = BIT_CYCLES;
    localparam int IDLE = (BIT * 21) / 2;
    int   cmdCnt_reg;
    int   stsCnt_reg;
    logic cmdPrev_reg;
    logic stsPrev_reg;
    logic owe_reg;
    logic cmdStart;
    logic stsStart;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // falls inside a frame never come later than 9 bits, so they are ignored
    assign cmdStart = cmdPrev_reg & ~commandLine & (cmdCnt_reg >= IDLE);
    assign stsStart = stsPrev_reg & ~statusLine & (stsCnt_reg >= IDLE);
    // cycles since each frame start, saturating when idle
    always_ff @(posedge clk) begin
        if (reset) begin
            cmdCnt_reg  <= IDLE;
            stsCnt_reg  <= IDLE;
            cmdPrev_reg <= 1'b1;
            stsPrev_reg <= 1'b1;
        end else begin
            cmdCnt_reg  <= cmdStart ? 0 : (cmdCnt_reg < IDLE ? cmdCnt_reg + 1 : IDLE);
            stsCnt_reg  <= stsStart ? 0 : (stsCnt_reg < IDLE ? stsCnt_reg + 1 : IDLE);
            cmdPrev_reg <= commandLine;
            stsPrev_reg <= statusLine;
        end
    end
    // reply owed between a command start and a status start
    always_ff @(posedge clk) begin
        if (reset) begin
            owe_reg <= 1'b0;
        end else if (cmdStart) begin
            owe_reg <= 1'b1;
        end else if (stsStart) begin
            owe_reg <= 1'b0;
        end
    end
    sequence held_low(logic s);
        !s [*8];
    endsequence
    a_cmd_start_hold: assert property ($fell(commandLine) |-> held_low(commandLine))
        else $error("command start bit too short");
    a_sts_start_hold: assert property ($fell(statusLine) |-> held_low(statusLine))
        else $error("status start bit too short");
    a_cmd_stop_high: assert property (cmdCnt_reg == IDLE - 1 |-> commandLine)
        else $error("command stop bit low");
    a_sts_stop_high: assert property (stsCnt_reg == IDLE - 1 |-> statusLine)
        else $error("status stop bit low");
    a_cmd_after_reply: assert property (cmdStart |-> !owe_reg)
        else $error("command sent while reply owed");
    a_reply_has_cmd: assert property (stsStart |-> owe_reg)
        else $error("status sent without command");
    a_vsync_one_cycle: assert property (vsync |=> !vsync)
        else $error("vsync longer than one cycle");
    a_vsync_on_req: assert property (vsync |-> $past(print_request))
        else $error("vsync without print request");
endmodule : engine_link_sva

// *** dv/engine_command_status_link_bench.sv ***
// Purpose: bench joining both link ends, frames checked on the wire
// Assumes: shortened bit time so the whole run stays brief
// Notes:   receiver error pulses are watched and must never fire on good frames
`timescale 1ns/1ns
module engine_command_status_link_bench;
    localparam int BIT   = 32;    // short bit keeps the run short; same logic as full rate
    localparam int LIMIT = 20000; // four characters plus margin
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       engineOk = 1'b0;
    logic [3:0] keySwitches = 4'h0;
    logic       pageStart = 1'b0;
    logic [7:0] stsIn = 8'h00;
    logic       stsSend = 1'b0;
    logic [7:0] cmdIn = 8'h00;
    logic       cmdSend = 1'b0;
    logic       pageWanted = 1'b0;
    logic       lineSync = 1'b0;
    logic       dot = 1'b0;
    logic       stsBusy, cmdValid, engLinkUp, awaitReply, laserOn, lineStart;
    logic       cmdReady, stsValid, ctlLinkUp, engineReady, keyChanged, pageTop;
    logic [7:0] cmdOut, stsOut;
    logic       cmdErr, stsErr;
    logic       errSeen = 1'b0;
    int         n_mismatch = 0;
    int         checked = 0;
    int         cycles = 0;
    engine_link_if lnk ();
    engine_end #(.BIT_CYCLES(BIT)) i_engine_end (.clk(clk), .reset(reset), .link(lnk),
        .engineOk(engineOk),
        .keySwitches(keySwitches), .pageStart(pageStart), .statusData(stsIn),
        .statusSend(stsSend), .statusBusy(stsBusy), .cmdData(cmdOut), .cmdValid(cmdValid),
        .cmdError(cmdErr), .linkUp(engLinkUp), .awaitReply(awaitReply), .laserOn(laserOn),
        .lineStart(lineStart));
    controller_end #(.BIT_CYCLES(BIT)) i_controller_end (.clk(clk), .reset(reset), .link(lnk),
        .cmdData(cmdIn),
        .cmdSend(cmdSend), .cmdReady(cmdReady), .statusData(stsOut), .statusValid(stsValid),
        .statusError(stsErr), .linkUp(ctlLinkUp), .pageWanted(pageWanted), .lineSync(lineSync),
        .dot(dot), .engineReady(engineReady), .keyChanged(keyChanged), .pageTop(pageTop));
    engine_link_sva #(.BIT_CYCLES(BIT)) i_engine_link_sva (.clk(clk), .reset(reset),
        .commandLine(lnk.commandLine),
        .statusLine(lnk.statusLine), .print_request(lnk.print_request), .vsync(lnk.vsync));
    always #4 clk = ~clk;
    // any receiver discard on a clean link is remembered for the end
    always @(posedge clk) begin
        if (cmdErr === 1'b1 || stsErr === 1'b1) errSeen <= 1'b1;
    end
    // hang guard: a run past the ceiling counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s: %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // samples one character at bit centres; mid-bit the line never moves
    task automatic frame(input logic sts, input logic [7:0] exp);
        logic [10:0] f;
        if (sts) @(negedge lnk.statusLine);
        else @(negedge lnk.commandLine);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = sts ? lnk.statusLine : lnk.commandLine;
            if (i < 10) repeat (BIT) @(posedge clk);
        end
        check({7'h00, f[0]}, 8'h00, "start bit");
        check(f[8:1], exp, "data bits");
        check({7'h00, f[9]}, {7'h00, ~^exp}, "parity bit");
        check({7'h00, f[10]}, 8'h01, "stop bit");
    endtask : frame
    task automatic waitPulse(input logic eng);
        int n;
        n = 0;
        tick;
        while ((eng ? cmdValid : stsValid) !== 1'b1 && n < 20 * BIT) begin
            tick;
            n++;
        end
        check({7'h00, n < 20 * BIT}, 8'h01, "character delivered");
    endtask : waitPulse
    task automatic command(input logic [7:0] b, input logic send);
        fork
            frame(1'b0, b);
            waitPulse(1'b1);
            if (send) begin
                cmdIn = b;
                cmdSend = 1'b1;
                tick;
                cmdSend = 1'b0;
            end
        join
        tick; // owed flag is registered twice after the pulse
        check(cmdOut, b, "command byte");
        check({7'h00, awaitReply}, 8'h01, "reply owed");
    endtask : command
    task automatic reply(input logic [7:0] b);
        fork
            frame(1'b1, b);
            waitPulse(1'b0);
            begin
                stsIn = b;
                stsSend = 1'b1;
                tick;
                stsSend = 1'b0;
            end
        join
        check({7'h00, stsBusy}, 8'h01, "stop bit still sending");
        tick; // ready is registered after the wait clears
        check(stsOut, b, "status byte");
        check({7'h00, cmdReady}, 8'h01, "ready for next");
    endtask : reply
    // main sequence: init, reply, discretes, one command, reply
    initial begin
        logic seen;
        repeat (16) tick;
        check({7'h00, engineReady}, 8'h00, "ready in reset");
        engineOk = 1'b1;
        pageWanted = 1'b1;
        reset = 1'b0;
        command(engine_link_pkg::CMD_INIT, 1'b0);
        check({7'h00, engLinkUp}, 8'h01, "engine link up");
        check({7'h00, engineReady}, 8'h01, "engine ready");
        reply(8'h5A);
        check({7'h00, ctlLinkUp}, 8'h01, "controller link up");
        // let the reply finish so an unasked send would really reach the line
        while (stsBusy === 1'b1) tick;
        stsSend = 1'b1;
        tick;
        stsSend = 1'b0;
        repeat (4) tick;
        check({7'h00, lnk.statusLine}, 8'h01, "unasked reply");
        keySwitches = 4'h5;
        repeat (4) tick;
        check({7'h00, keyChanged}, 8'h01, "key change flagged");
        seen = 1'b0;
        pageStart = 1'b1;
        tick;
        pageStart = 1'b0;
        repeat (6) begin
            tick;
            if (pageTop === 1'b1) seen = 1'b1;
        end
        check({7'h00, seen}, 8'h01, "page top");
        lineSync = 1'b1;
        dot = 1'b1;
        repeat (4) tick;
        check({7'h00, lineStart}, 8'h01, "line sync");
        check({7'h00, laserOn}, 8'h01, "laser on");
        dot = 1'b0;
        repeat (4) tick;
        check({7'h00, laserOn}, 8'h00, "laser off");
        command(8'hC3, 1'b1);
        repeat (3) tick;
        check({7'h00, keyChanged}, 8'h00, "key change cleared");
        cmdIn = 8'hFF;
        cmdSend = 1'b1;
        tick;
        cmdSend = 1'b0;
        repeat (8) tick;
        check({7'h00, lnk.commandLine}, 8'h01, "command while owed");
        reply(8'h81);
        check({7'h00, errSeen}, 8'h00, "receiver error");
        complete_run();
    end
endmodule : engine_command_status_link_bench
